// ===== spi_slave_unit_tx.v
// SPI slave transmit side: buffer limits, byte count, serial format and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_unit_tx_consts.vh"
module spi_slave_unit_tx #(
  parameter ADDR_W = 16
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [11:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [11:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              sck,
  input  wire              chip_select_n,
  output reg               miso_o,
  output reg               miso_oe,
  output reg  [ADDR_W-1:0] tx_fetch_addr,
  input  wire [7:0]        tx_fetch_data,
  output reg               buffers_granted
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_XFER = 2'b10;
  localparam integer START_CYC = `START_CYCLES;
  localparam [2:0]   START_CNT = START_CYC[2:0];

  // Registers
  reg [12:0]       limit_reg;
  reg [12:0]       done_reg;
  reg [1:0]        list_reg;
  reg [2:0]        cfg_reg;
  reg [7:0]        def_reg;
  reg [7:0]        orc_reg;
  reg [ADDR_W-1:0] base_reg;
  reg [2:0]        rel_cnt_reg;
  // Bus side
  reg              aw_have_reg;
  reg              w_have_reg;
  reg [11:0]       awaddr_reg;
  reg [31:0]       wdata_reg;
  reg [3:0]        wstrb_reg;
  // Serial side
  reg [1:0]        state_reg;
  reg              ignore_reg;
  reg [7:0]        sh_reg;
  reg [2:0]        out_cnt_reg;
  reg [2:0]        smp_cnt_reg;
  reg [12:0]       load_idx_reg;
  reg [12:0]       sent_cnt_reg;
  reg              sck_prev_reg;
  wire [1:0]       pins_q;
  wire             sck_q;
  wire             csn_q;

  pin_sync3 #(
    .W    (2),
    .INIT (2'b10)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({chip_select_n, sck}),
    .q       (pins_q)
  );
  assign sck_q = pins_q[0];
  assign csn_q = pins_q[1];

  wire order_low = cfg_reg[`CFG_ORDER_BIT];
  wire phase     = cfg_reg[`CFG_PHASE_BIT];
  wire pol       = cfg_reg[`CFG_POL_BIT];
  wire sck_rise  = sck_q & ~sck_prev_reg;
  wire sck_fall  = ~sck_q & sck_prev_reg;
  wire lead_edge = pol ? sck_fall : sck_rise;
  wire trail_edge = pol ? sck_rise : sck_fall;
  // phase picks sample and shift edges
  wire smp_edge  = phase ? trail_edge : lead_edge;
  wire sft_edge  = phase ? lead_edge : trail_edge;
  wire cs_start  = (state_reg == ST_IDLE) && !csn_q;
  wire cs_end    = (state_reg == ST_XFER) && csn_q;

  // Character choice for the next byte
  wire       ign_now   = cs_start ? !buffers_granted : ignore_reg;
  wire       over_now  = (load_idx_reg >= limit_reg);
  reg  [7:0] next_char;
  always @* begin
    if (ign_now) begin
      next_char = def_reg;
    end else if (over_now) begin
      next_char = orc_reg;
    end else begin
      next_char = tx_fetch_data;
    end
  end

  wire       load_now = cs_start || (out_cnt_reg == 3'h0);
  wire [7:0] cur_char = load_now ? next_char : sh_reg;
  wire       out_bit  = order_low ? cur_char[0] : cur_char[7];
  wire [7:0] sh_next  = order_low ? {1'b0, cur_char[7:1]} : {cur_char[6:0], 1'b0};
  wire       emit     = cs_start ? !phase : ((state_reg == ST_XFER) && sft_edge);
  wire       from_buf = load_now && !ign_now && !over_now;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_IDLE;
      ignore_reg    <= 1'b0;
      sh_reg        <= `RST_CHAR;
      out_cnt_reg   <= 3'h0;
      smp_cnt_reg   <= 3'h0;
      load_idx_reg  <= 13'h0000;
      sent_cnt_reg  <= 13'h0000;
      sck_prev_reg  <= 1'b0;
      miso_o        <= 1'b0;
      miso_oe       <= 1'b0;
      tx_fetch_addr <= {ADDR_W{1'b0}};
    end else begin
      sck_prev_reg  <= sck_q;
      tx_fetch_addr <= base_reg + {{(ADDR_W-13){1'b0}}, load_idx_reg};
      case (state_reg)
        ST_IDLE: begin
          if (cs_start) begin
            state_reg    <= ST_XFER;
            ignore_reg   <= !buffers_granted;
            miso_oe      <= 1'b1;
            smp_cnt_reg  <= 3'h0;
            sent_cnt_reg <= 13'h0000;
            load_idx_reg <= 13'h0000;
            out_cnt_reg  <= 3'h0;
            // phase 0 drives first bit before first edge
            if (emit) begin
              miso_o      <= out_bit;
              sh_reg      <= sh_next;
              out_cnt_reg <= 3'h1;
              if (from_buf) begin
                load_idx_reg <= 13'h0001;
              end
            end
          end
        end
        ST_XFER: begin
          if (cs_end) begin
            state_reg <= ST_IDLE;
            miso_oe   <= 1'b0;
            // Fetch of byte zero settles while idle
            load_idx_reg <= 13'h0000;
          end else begin
            if (emit) begin
              miso_o      <= out_bit;
              sh_reg      <= sh_next;
              out_cnt_reg <= out_cnt_reg + 3'h1;
              if (from_buf) begin
                load_idx_reg <= load_idx_reg + 13'h0001;
              end
            end
            if (smp_edge) begin
              smp_cnt_reg <= smp_cnt_reg + 3'h1;
              // count whole bytes from the buffer only
              if (smp_cnt_reg == 3'h7 && !ignore_reg && sent_cnt_reg < limit_reg) begin
                sent_cnt_reg <= sent_cnt_reg + 13'h0001;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          miso_oe   <= 1'b0;
        end
      endcase
    end
  end

  // Bus write path
  wire       wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [31:0] wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  reg  [31:0] old_word;
  reg         wr_known;
  always @* begin
    wr_known = 1'b1;
    case (awaddr_reg)
      `OFS_TX_LIMIT: old_word = {19'h0_0000, limit_reg};
      `OFS_TX_LIST:  old_word = {30'h0000_0000, list_reg};
      `OFS_CONFIG:   old_word = {29'h0000_0000, cfg_reg};
      `OFS_DEF_CHAR: old_word = {24'h00_0000, def_reg};
      `OFS_ORC_CHAR: old_word = {24'h00_0000, orc_reg};
      `OFS_RELEASE:  old_word = `RST_WORD;
      `OFS_TX_DONE:  old_word = `RST_WORD;
      `OFS_STATUS:   old_word = `RST_WORD;
      default: begin
        old_word = `RST_WORD;
        wr_known = 1'b0;
      end
    endcase
  end
  wire [31:0] new_word = (old_word & ~wmask) | (wdata_reg & wmask);
  wire        rel_req  = wr_fire && (awaddr_reg == `OFS_RELEASE) && wstrb_reg[0] && wdata_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= `RST_WORD;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      limit_reg     <= `RST_LIMIT;
      list_reg      <= 2'h0;
      cfg_reg       <= 3'h0;
      def_reg       <= `RST_CHAR;
      orc_reg       <= `RST_CHAR;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        case (awaddr_reg)
          `OFS_TX_LIMIT: limit_reg <= new_word[12:0];
          `OFS_TX_LIST:  list_reg  <= new_word[1:0];
          `OFS_CONFIG:   cfg_reg   <= new_word[2:0];
          `OFS_DEF_CHAR: def_reg   <= new_word[7:0];
          `OFS_ORC_CHAR: orc_reg   <= new_word[7:0];
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
    end
  end

  // Ownership handshake; busy transactions keep the grant they started with
  always @(posedge aclk) begin
    if (!aresetn) begin
      rel_cnt_reg     <= 3'h0;
      buffers_granted <= 1'b0;
      done_reg        <= 13'h0000;
      base_reg        <= {ADDR_W{1'b0}};
    end else begin
      if (rel_req && !buffers_granted) begin
        rel_cnt_reg <= START_CNT;
      end else if (rel_cnt_reg != 3'h0) begin
        rel_cnt_reg <= rel_cnt_reg - 3'h1;
        if (rel_cnt_reg == 3'h1) begin
          buffers_granted <= 1'b1;
        end
      end
      // count latched at chip select release
      if (cs_end && !ignore_reg) begin
        done_reg        <= sent_cnt_reg;
        buffers_granted <= 1'b0;
        if (list_reg == `LIST_ARRAY) begin
          base_reg <= base_reg + {{(ADDR_W-13){1'b0}}, limit_reg};
        end
      end
    end
  end

  // Bus read path, one read at a time
  reg [31:0] rd_word;
  reg        rd_known;
  always @* begin
    rd_known = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `OFS_TX_LIMIT: rd_word = {19'h0_0000, limit_reg};
      `OFS_TX_DONE:  rd_word = {19'h0_0000, done_reg};
      `OFS_TX_LIST:  rd_word = {30'h0000_0000, list_reg};
      `OFS_CONFIG:   rd_word = {29'h0000_0000, cfg_reg};
      `OFS_DEF_CHAR: rd_word = {24'h00_0000, def_reg};
      `OFS_ORC_CHAR: rd_word = {24'h00_0000, orc_reg};
      `OFS_RELEASE:  rd_word = `RST_WORD;
      `OFS_STATUS:   rd_word = {29'h0000_0000, (rel_cnt_reg != 3'h0),
                                (state_reg == ST_XFER), buffers_granted};
      default: begin
        rd_word  = `RST_WORD;
        rd_known = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== spi_slave_unit_tx_consts.vh
// Register map, field positions, reset values and timing counts of the slave transmit block
`ifndef SPI_SLAVE_UNIT_TX_CONSTS_VH
`define SPI_SLAVE_UNIT_TX_CONSTS_VH

`define OFS_RELEASE      12'h03C
`define OFS_STATUS       12'h400
`define OFS_TX_LIMIT     12'h548
`define OFS_TX_DONE      12'h54C
`define OFS_TX_LIST      12'h550
`define OFS_CONFIG       12'h554
`define OFS_DEF_CHAR     12'h55C
`define OFS_ORC_CHAR     12'h5C0

`define CFG_ORDER_BIT    0
`define CFG_PHASE_BIT    1
`define CFG_POL_BIT      2
`define LIST_ARRAY       2'h1
`define STAT_GRANT_BIT   0
`define STAT_BUSY_BIT    1
`define STAT_WAIT_BIT    2

`define RST_WORD         32'h0000_0000
`define RST_LIMIT        13'h0000
`define RST_CHAR         8'h00
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define CLK_PERIOD_NS    50
`define START_TIME_PS    125000
`define START_CYCLES     ((`START_TIME_PS + `CLK_PERIOD_NS * 1000 - 1) / (`CLK_PERIOD_NS * 1000))

`endif

// ===== pin_sync3.v
// Three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter       W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] hold_reg;
  integer     i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg   <= INIT;
      s2_reg   <= INIT;
      s3_reg   <= INIT;
      hold_reg <= INIT;
    end else begin
      s1_reg   <= d;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      hold_reg <= q;
    end
  end

  // No register after the agreement test: saves a cycle of edge latency
  always @* begin
    q = hold_reg;
    for (i = 0; i < W; i = i + 1) begin
      // Single-sample glitches never reach q
      if (s2_reg[i] == s3_reg[i]) begin
        q[i] = s3_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tx_config_monitor.sv
// Port checker of the slave transmit block
`timescale 1ns/1ps
`default_nettype none
module tx_config_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        chip_select_n,
  input wire logic        miso_oe,
  input wire logic        buffers_granted
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rel_reg;
  // Release write seen, kept until its response
  always @(posedge aclk) begin
    if (!aresetn)
      rel_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      rel_reg <= (s_axi_awaddr == 12'h03C) && s_axi_wdata[0];
  end
  bdone_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  banswer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  ranswer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  oe_on_a: assert property ($fell(chip_select_n) |-> ##[2:6] miso_oe)
    else $error("data line not driven");
  quiet_a: assert property (chip_select_n [*8] |-> !miso_oe)
    else $error("data line driven while idle");
  grant_a: assert property (
    s_axi_bvalid && s_axi_bready && rel_reg && !buffers_granted |-> ##[2:3] buffers_granted)
    else $error("grant late");
  grant_end_a: assert property (
    $rose(chip_select_n) && buffers_granted |-> ##[1:7] !buffers_granted)
    else $error("grant kept after transaction");
endmodule
`default_nettype wire

// ===== spi_master_model.sv
// Serial master model: makes clock and select, samples the data line
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output var logic sck,
  output var logic chip_select_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  logic last_lvl;
  logic seen;
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
  end
  // Released line shows the inverse of its last level, never a held value
  always @(negedge miso_oe) last_lvl = miso_o;
  assign seen = miso_oe ? miso_o : ~last_lvl;
  task automatic xfer(input logic pol, input logic pha, input int n, output logic [31:0] got);
    got = 32'h0000_0000;
    #13 sck = pol;
    #300 chip_select_n = 1'b0;
    #600;
    for (int i = 0; i < 8 * n; i++) begin
      sck = ~pol;
      if (!pha) got[8 * (i / 8) + 7 - i % 8] = seen;
      #200 sck = pol;
      if (pha) got[8 * (i / 8) + 7 - i % 8] = seen;
      #200;
    end
    chip_select_n = 1'b1;
    #600;
  endtask
endmodule
`default_nettype wire

// ===== tb_spi_slave_tx_config.sv
// Bench of the slave transmit block against a serial master model
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_unit_tx_consts.vh"
module tb_spi_slave_tx_config;
  logic        aclk, aresetn, sck, chip_select_n, miso_o, miso_oe, buffers_granted;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] tx_fetch_addr;
  logic [7:0]  tx_fetch_data, dch, och;
  logic [12:0] lim, cnt;
  logic [2:0]  cfg;
  logic        g, lst;
  logic [11:0] ofs [6] = '{`OFS_TX_LIMIT, `OFS_TX_DONE, `OFS_TX_LIST, `OFS_CONFIG,
                           `OFS_DEF_CHAR, `OFS_ORC_CHAR};
  int          bad_count, checked, cyc, base, n;
  spi_slave_unit_tx uut (.*);
  spi_master_model far (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  always @(posedge aclk) begin
    tx_fetch_data <= mem(tx_fetch_addr);
    cyc <= cyc + 1;
    // Run needs under ten thousand cycles
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata);
  endtask
  function automatic logic [31:0] expect_word();
    logic [7:0] b;
    expect_word = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      b = !g ? dch : (i >= lim) ? och : mem(16'(base + i));
      // Low bit first lands reversed in the master's shift order
      if (cfg[0]) b = {<<{b}};
      expect_word[8 * i +: 8] = b;
    end
  endfunction
  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    cnt = 13'h0000;
    got = $urandom(32'h002B_3AF9);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    foreach (ofs[i]) rd_chk(ofs[i], `RST_WORD, `RESP_OKAY);
    wr(`OFS_TX_LIMIT, 32'hFFFF_FFFF, `RESP_OKAY);
    rd_chk(`OFS_TX_LIMIT, 32'h0000_1FFF, `RESP_OKAY);
    wr(`OFS_TX_DONE, 32'h0000_0055, `RESP_OKAY);
    rd_chk(`OFS_TX_DONE, 32'h0000_0000, `RESP_OKAY);
    wr(12'h7F0, 32'h0000_0001, `RESP_SLVERR);
    rd_chk(12'h7F0, 32'h0000_0000, `RESP_SLVERR);
    for (int k = 0; k < 12; k++) begin
      cfg = 3'(k);
      lim = (k < 2) ? 13'h0001 : 13'($urandom_range(3, 1));
      n = $urandom_range(4, 1);
      dch = 8'($urandom);
      och = 8'($urandom);
      lst = 1'($urandom);
      g = (k % 3 != 2);
      wr(`OFS_CONFIG, {29'h0, cfg}, `RESP_OKAY);
      wr(`OFS_TX_LIMIT, {19'h0, lim}, `RESP_OKAY);
      wr(`OFS_TX_LIST, {31'h0, lst}, `RESP_OKAY);
      wr(`OFS_DEF_CHAR, {24'h0, dch}, `RESP_OKAY);
      wr(`OFS_ORC_CHAR, {24'h0, och}, `RESP_OKAY);
      rd_chk(`OFS_ORC_CHAR, {24'h0, och}, `RESP_OKAY);
      if (g) wr(`OFS_RELEASE, 32'h0000_0001, `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("granted", {31'h0, g}, {31'h0, buffers_granted});
      rd_chk(`OFS_STATUS, {31'h0, g}, `RESP_OKAY);
      far.xfer(cfg[2], cfg[1], n, got);
      chk("bytes", expect_word(), got);
      if (g) cnt = (n < lim) ? 13'(n) : lim;
      rd_chk(`OFS_TX_DONE, {19'h0, cnt}, `RESP_OKAY);
      chk("granted", 32'h0000_0000, {31'h0, buffers_granted});
      if (g && lst) base += lim;
    end
    close_out();
  end
endmodule
bind spi_slave_unit_tx tx_config_monitor mon (.*);
`default_nettype wire
